// file: verilog/ssx_exec.sv
// decode of subtract, decode and execute of borrow-subtract, swap, trap and exchange
// assumes one instruction byte per enabled cycle with byte_vld, and a core
// that supplies register and memory operands for the current instruction
//
// Contract
// - native 9E, reg nibble and 0000, immediate byte: byte_reg minus imm.
// - low nibble 0100: 16-bit immediate high byte first from word_reg.
// - low nibble 1000: 16-bit immediate from dword_reg, 5 states native.
// - compat mode needs A5 escape for these forms, one more byte and state.
// - nibble 0001/0101 with address byte subtracts short location from reg.
// - nibble 0011/0111 with two address bytes subtracts long location.
// - nibble 1001/1011 subtract byte at word_reg or dword_reg pointer.
// - short location on ports 0 to 3 adds one state to subtracts.
// - 95 with address: accumulator minus short location and carry.
// - indirect and bank borrow forms one byte compat, A5 native.
// - borrow-subtract also subtracts the prior carry_flag.
// - trap drops stack pointer by 2, jumps to vector.
`include "ssx_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ssx_exec (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // mode: high selects native encoding
    input wire logic native_mode,
    // instruction byte stream
    input wire logic byte_vld,
    input wire logic [7:0] byte_in,
    // operand from register file or memory
    input wire logic [7:0] src_byte,
    // decoded instruction and state
    output logic dec_vld,
    output ssx_pkg::ssx_dec_t dec,
    output logic [7:0] accumulator,
    output ssx_pkg::ssx_flags_t flags,
    output logic [15:0] stack_pointer_reg,
    output logic [23:0] program_counter,
    output logic int_block,
    output logic mem_we,
    output logic [7:0] mem_wdata,
    output logic bad_opcode
);
    ssx_pkg::ssx_st_t s_r;
    ssx_pkg::ssx_st_t s_nxt;
    logic [8:0] diff;
    logic [4:0] hdiff;
    logic is_port;
    logic [3:0] base;
    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.dec_vld = 1'b0;
        s_nxt.mem_we = 1'b0;
        s_nxt.int_block = 1'b0;
        s_nxt.bad = 1'b0;
        diff = 9'h000;
        hdiff = 5'h00;
        base = 4'h0;
        is_port = (s_r.opnd[7:0] <= `SSX_PORT_LAST);
        case (s_r.st)
            ssx_pkg::SSX_IDLE, ssx_pkg::SSX_OPC:
            begin
                if (byte_vld && byte_in == `SSX_ESC_BYTE && !s_r.esc)
                begin
                    s_nxt.esc = 1'b1;
                    s_nxt.st = ssx_pkg::SSX_OPC;
                end
                else if (byte_vld)
                begin
                    s_nxt.op = byte_in;
                    s_nxt.opnd = 16'h0000;
                    s_nxt.dec = '0;
                    s_nxt.st = ssx_pkg::SSX_OPND;
                    s_nxt.need = 2'd1;
                    if (byte_in == `SSX_OP_EXT)
                    begin
                        // extended forms need escape in compat mode
                        if (native_mode == s_r.esc)
                        begin
                            s_nxt.bad = 1'b1;
                            s_nxt.st = ssx_pkg::SSX_IDLE;
                        end
                    end
                    else if (byte_in[7:4] == 4'h9 &&
                             (byte_in[3] || byte_in[3:1] == 3'b011))
                    begin
                        // indirect and bank forms escape in native mode
                        if (native_mode != s_r.esc)
                        begin
                            s_nxt.bad = 1'b1;
                            s_nxt.st = ssx_pkg::SSX_IDLE;
                        end
                        else
                        begin
                            s_nxt.dec.kind = ssx_pkg::SSX_K_SBB;
                            s_nxt.dec.src = byte_in[3] ? ssx_pkg::SSX_SRC_RN
                                                       : ssx_pkg::SSX_SRC_RI;
                            s_nxt.dec.reg_sel = {1'b0, byte_in[2:0]};
                            // the escaped native form costs one more state
                            s_nxt.dec.states = (byte_in[3] ? 4'h1 : 4'h2) +
                                {3'b000, s_r.esc};
                            s_nxt.need = 2'd0;
                            s_nxt.st = ssx_pkg::SSX_WAIT;
                        end
                    end
                    else if (byte_in == `SSX_OP_SWAP || byte_in == `SSX_OP_TRAP)
                    begin
                        s_nxt.need = 2'd0;
                        s_nxt.st = ssx_pkg::SSX_WAIT;
                    end
                    else if (byte_in != `SSX_OP_SBB_IMM &&
                             byte_in != `SSX_OP_SBB_DIR &&
                             byte_in != `SSX_OP_XCH_DIR)
                    begin
                        s_nxt.bad = 1'b1;
                        s_nxt.st = ssx_pkg::SSX_IDLE;
                    end
                    s_nxt.esc = 1'b0;
                end
            end
            ssx_pkg::SSX_OPND:
            begin
                if (byte_vld)
                begin
                    if (s_r.op == `SSX_OP_EXT && s_r.dec.kind ==
                        ssx_pkg::SSX_K_NONE)
                    begin
                        s_nxt.sub = byte_in;
                        s_nxt.dec.reg_sel = byte_in[7:4];
                        s_nxt.dec.states = 4'h1;
                        s_nxt.dec.kind = ssx_pkg::SSX_K_SUB_B;
                        case (byte_in[3:0])
                            `SSX_LN_RM_IMM: begin s_nxt.need = 2'd1;
                                s_nxt.dec.states = 4'h2;
                                s_nxt.dec.src = ssx_pkg::SSX_SRC_IMM; end
                            `SSX_LN_WR_IMM: begin s_nxt.need = 2'd2;
                                s_nxt.dec.kind = ssx_pkg::SSX_K_SUB_W;
                                s_nxt.dec.states = 4'h3;
                                s_nxt.dec.src = ssx_pkg::SSX_SRC_IMM; end
                            `SSX_LN_DR_IMM: begin s_nxt.need = 2'd2;
                                s_nxt.dec.kind = ssx_pkg::SSX_K_SUB_D;
                                s_nxt.dec.states = `SSX_DR_IMM_STATES;
                                s_nxt.dec.src = ssx_pkg::SSX_SRC_IMM; end
                            `SSX_LN_RM_DIR, `SSX_LN_WR_DIR:
                            begin s_nxt.need = 2'd1;
                                s_nxt.dec.src = ssx_pkg::SSX_SRC_DIR;
                                if (byte_in[2])
                                    s_nxt.dec.kind = ssx_pkg::SSX_K_SUB_W;
                                s_nxt.dec.states = byte_in[2] ? 4'h3 : 4'h2; end
                            `SSX_LN_RM_D16, `SSX_LN_WR_D16:
                            begin s_nxt.need = 2'd2;
                                s_nxt.dec.src = ssx_pkg::SSX_SRC_D16;
                                if (byte_in[2])
                                    s_nxt.dec.kind = ssx_pkg::SSX_K_SUB_W;
                                s_nxt.dec.states = byte_in[2] ? 4'h3 : 4'h2; end
                            `SSX_LN_RM_IWR, `SSX_LN_RM_IDR:
                            begin s_nxt.need = 2'd1;
                                s_nxt.dec.src = byte_in[1] ?
                                    ssx_pkg::SSX_SRC_IDR : ssx_pkg::SSX_SRC_IWR;
                                s_nxt.dec.states = byte_in[1] ? 4'h3 : 4'h2; end
                            default: begin s_nxt.bad = 1'b1;
                                s_nxt.st = ssx_pkg::SSX_IDLE; end
                        endcase
                    end
                    else
                    begin
                        s_nxt.opnd = {s_r.opnd[7:0], byte_in};
                        s_nxt.need = s_r.need - 2'd1;
                        if (s_r.dec.src == ssx_pkg::SSX_SRC_IWR ||
                            s_r.dec.src == ssx_pkg::SSX_SRC_IDR)
                            s_nxt.dec.dst_sel = byte_in[7:4];
                        if (s_r.need == 2'd1)
                            s_nxt.st = ssx_pkg::SSX_WAIT;
                    end
                end
            end
            ssx_pkg::SSX_WAIT:
            begin
                case (s_r.op)
                    `SSX_OP_SBB_IMM: begin s_nxt.dec.kind = ssx_pkg::SSX_K_SBB;
                        s_nxt.dec.states = 4'h1; end
                    `SSX_OP_SBB_DIR: begin s_nxt.dec.kind = ssx_pkg::SSX_K_SBB;
                        s_nxt.dec.src = ssx_pkg::SSX_SRC_DIR;
                        s_nxt.dec.states = is_port ? 4'h2 : 4'h1; end
                    `SSX_OP_SWAP: begin s_nxt.dec.kind = ssx_pkg::SSX_K_SWAP;
                        s_nxt.dec.states = `SSX_SWAP_STATES; end
                    `SSX_OP_TRAP: begin s_nxt.dec.kind = ssx_pkg::SSX_K_TRAP;
                        s_nxt.dec.states = 4'ha; end
                    `SSX_OP_XCH_DIR: begin s_nxt.dec.kind = ssx_pkg::SSX_K_XCH;
                        s_nxt.dec.src = ssx_pkg::SSX_SRC_DIR;
                        s_nxt.dec.states = 4'h3 +
                            (is_port ? `SSX_XCH_PORT_ADD : 4'h0); end
                    `SSX_OP_EXT:
                        if (s_r.dec.src == ssx_pkg::SSX_SRC_DIR && is_port)
                            s_nxt.dec.states = s_r.dec.states +
                                `SSX_DIR_PORT_ADD;
                    default: ;
                endcase
                if (s_r.op == `SSX_OP_EXT && !native_mode)
                    s_nxt.dec.states = s_nxt.dec.states + 4'h1;
                base = s_nxt.dec.states;
                s_nxt.dec.operand = s_r.opnd;
                s_nxt.cnt = (base == 4'h0) ? 4'h0 : base - 4'h1;
                s_nxt.st = ssx_pkg::SSX_DONE;
            end
            ssx_pkg::SSX_DONE:
            begin
                if (s_r.cnt != 4'h0)
                    s_nxt.cnt = s_r.cnt - 4'h1;
                else
                begin
                    s_nxt.dec_vld = 1'b1;
                    s_nxt.st = ssx_pkg::SSX_IDLE;
                    case (s_r.dec.kind)
                        ssx_pkg::SSX_K_SBB:
                        begin
                            diff = {1'b0, s_r.acc} -
                                {1'b0, (s_r.dec.src == ssx_pkg::SSX_SRC_IMM) ?
                                s_r.opnd[7:0] : src_byte} -
                                {8'h00, s_r.fl.cy};
                            hdiff = {1'b0, s_r.acc[3:0]} -
                                {1'b0, (s_r.dec.src == ssx_pkg::SSX_SRC_IMM) ?
                                s_r.opnd[3:0] : src_byte[3:0]} -
                                {4'h0, s_r.fl.cy};
                            s_nxt.acc = diff[7:0];
                            s_nxt.fl.cy = diff[8];
                            s_nxt.fl.ac = hdiff[4];
                            s_nxt.fl.ov = (s_r.acc[7] != ((s_r.dec.src ==
                                ssx_pkg::SSX_SRC_IMM) ? s_r.opnd[7]
                                : src_byte[7])) && (diff[7] != s_r.acc[7]);
                        end
                        ssx_pkg::SSX_K_SWAP:
                            s_nxt.acc = {s_r.acc[3:0], s_r.acc[7:4]};
                        ssx_pkg::SSX_K_TRAP:
                        begin
                            s_nxt.sp = s_r.sp - `SSX_SP_DEC;
                            s_nxt.pc = `SSX_TRAP_VEC;
                            s_nxt.int_block = 1'b1;
                        end
                        ssx_pkg::SSX_K_XCH:
                        begin
                            s_nxt.acc = src_byte;
                            s_nxt.mem_wdata = s_r.acc;
                            s_nxt.mem_we = 1'b1;
                        end
                        default: ;
                    endcase
                end
            end
            default: s_nxt.st = ssx_pkg::SSX_IDLE;
        endcase
    end
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            s_r <= '0;
        else if (ce)
            s_r <= s_nxt;
    end
    assign dec_vld = s_r.dec_vld;
    assign dec = s_r.dec;
    assign accumulator = s_r.acc;
    assign flags = s_r.fl;
    assign stack_pointer_reg = s_r.sp;
    assign program_counter = s_r.pc;
    assign int_block = s_r.int_block;
    assign mem_we = s_r.mem_we;
    assign mem_wdata = s_r.mem_wdata;
    assign bad_opcode = s_r.bad;
    ////////////////////////////////////////////////////////////////////////
    chk_swap_halves: assert property (@(posedge clk) disable iff (!rst_n)
        ce && s_r.st == ssx_pkg::SSX_DONE && s_r.cnt == 4'h0 &&
        s_r.dec.kind == ssx_pkg::SSX_K_SWAP |=> accumulator ==
        {$past(s_r.acc[3:0]), $past(s_r.acc[7:4])})
        else $error("swap result wrong");
    chk_swap_flags: assert property (@(posedge clk) disable iff (!rst_n)
        dec_vld && dec.kind == ssx_pkg::SSX_K_SWAP |-> flags == $past(flags))
        else $error("swap changed flags");
    chk_trap_sp: assert property (@(posedge clk) disable iff (!rst_n)
        dec_vld && dec.kind == ssx_pkg::SSX_K_TRAP |->
        stack_pointer_reg == $past(stack_pointer_reg) - 16'h0002)
        else $error("trap stack step wrong");
    chk_trap_vec: assert property (@(posedge clk) disable iff (!rst_n)
        dec_vld && dec.kind == ssx_pkg::SSX_K_TRAP |->
        program_counter == 24'hff007b && int_block)
        else $error("trap vector or block wrong");
    chk_xch_write: assert property (@(posedge clk) disable iff (!rst_n)
        dec_vld && dec.kind == ssx_pkg::SSX_K_XCH |->
        mem_we && mem_wdata == $past(accumulator) && flags == $past(flags))
        else $error("exchange write wrong");
    chk_sbb_carry: assert property (@(posedge clk) disable iff (!rst_n)
        dec_vld && dec.kind == ssx_pkg::SSX_K_SBB &&
        dec.src == ssx_pkg::SSX_SRC_IMM |-> flags.cy ==
        ({1'b0, $past(accumulator)} < ({1'b0, dec.operand[7:0]} +
        {8'h00, $past(flags.cy)})))
        else $error("borrow flag wrong");
    chk_sbb_result: assert property (@(posedge clk) disable iff (!rst_n)
        dec_vld && dec.kind == ssx_pkg::SSX_K_SBB &&
        dec.src == ssx_pkg::SSX_SRC_IMM |-> accumulator ==
        8'($past(accumulator) - dec.operand[7:0] - {7'h00, $past(flags.cy)}))
        else $error("borrow subtract result wrong");
    chk_dr_states: assert property (@(posedge clk) disable iff (!rst_n)
        dec_vld && dec.kind == ssx_pkg::SSX_K_SUB_D &&
        dec.src == ssx_pkg::SSX_SRC_IMM |-> dec.states ==
        (native_mode ? 4'h5 : 4'h6))
        else $error("dword immediate states wrong");
    cov_swap: cover property (@(posedge clk) dec_vld &&
        dec.kind == ssx_pkg::SSX_K_SWAP);
    cov_trap: cover property (@(posedge clk) dec_vld &&
        dec.kind == ssx_pkg::SSX_K_TRAP);
    cov_xch: cover property (@(posedge clk) dec_vld &&
        dec.kind == ssx_pkg::SSX_K_XCH);
    cov_sub_w: cover property (@(posedge clk) dec_vld &&
        dec.kind == ssx_pkg::SSX_K_SUB_W);
endmodule // ssx_exec
`default_nettype wire

// file: shared/ssx_defs.svh
// constants for the subtract/swap/trap/exchange execution block
// assumes inclusion by bare name from design files
`ifndef SSX_DEFS_SVH
`define SSX_DEFS_SVH
`define SSX_ESC_BYTE 8'ha5
`define SSX_OP_EXT 8'h9e
`define SSX_OP_SBB_IMM 8'h94
`define SSX_OP_SBB_DIR 8'h95
`define SSX_OP_SWAP 8'hc4
`define SSX_OP_TRAP 8'hb9
`define SSX_OP_XCH_DIR 8'hc5
`define SSX_LN_RM_IMM 4'h0
`define SSX_LN_RM_DIR 4'h1
`define SSX_LN_RM_D16 4'h3
`define SSX_LN_WR_IMM 4'h4
`define SSX_LN_WR_DIR 4'h5
`define SSX_LN_WR_D16 4'h7
`define SSX_LN_DR_IMM 4'h8
`define SSX_LN_RM_IWR 4'h9
`define SSX_LN_RM_IDR 4'hb
`define SSX_TRAP_VEC 24'hff007b
`define SSX_SP_DEC 16'h0002
`define SSX_PORT_LAST 8'h03
`define SSX_DR_IMM_STATES 4'h5
`define SSX_SWAP_STATES 4'h2
`define SSX_XCH_PORT_ADD 4'h2
`define SSX_DIR_PORT_ADD 4'h1
`endif

// file: shared/ssx_pkg.sv
// types for the subtract/swap/trap/exchange execution block
// assumes nothing beyond a SystemVerilog compiler
package ssx_pkg;
    typedef enum logic [2:0] {
        SSX_IDLE = 3'b000,
        SSX_OPC = 3'b001,
        SSX_OPND = 3'b010,
        SSX_WAIT = 3'b011,
        SSX_DONE = 3'b100
    } ssx_state_t;
    typedef enum logic [3:0] {
        SSX_K_NONE = 4'h0,
        SSX_K_SUB_B = 4'h1,
        SSX_K_SUB_W = 4'h2,
        SSX_K_SUB_D = 4'h3,
        SSX_K_SBB = 4'h4,
        SSX_K_SWAP = 4'h5,
        SSX_K_TRAP = 4'h6,
        SSX_K_XCH = 4'h7
    } ssx_kind_t;
    typedef enum logic [2:0] {
        SSX_SRC_IMM = 3'b000,
        SSX_SRC_DIR = 3'b001,
        SSX_SRC_D16 = 3'b010,
        SSX_SRC_IWR = 3'b011,
        SSX_SRC_IDR = 3'b100,
        SSX_SRC_RI = 3'b101,
        SSX_SRC_RN = 3'b110
    } ssx_src_t;
    // one decoded instruction handed to the core
    typedef struct packed {
        ssx_kind_t kind;
        ssx_src_t src;
        logic [3:0] reg_sel;
        logic [3:0] dst_sel;
        logic [15:0] operand;
        logic [3:0] states;
    } ssx_dec_t;
    typedef struct packed {
        logic cy;
        logic ac;
        logic ov;
    } ssx_flags_t;
    typedef struct packed {
        ssx_state_t st;
        logic esc;
        logic [7:0] op;
        logic [7:0] sub;
        logic [1:0] need;
        logic [15:0] opnd;
        logic [3:0] cnt;
        ssx_dec_t dec;
        logic dec_vld;
        logic [7:0] acc;
        ssx_flags_t fl;
        logic [15:0] sp;
        logic [23:0] pc;
        logic int_block;
        logic [7:0] mem_wdata;
        logic mem_we;
        logic bad;
    } ssx_st_t;
endpackage

// file: test/ssx_prog_mem.sv
// program memory model: feeds instruction bytes, first byte highest
// assumes the bench calls send only after the previous result is seen
`timescale 1ns/1ps
`default_nettype none
module ssx_prog_mem (
    // clock
    input wire logic clk,
    // instruction byte stream
    output logic byte_vld,
    output logic [7:0] byte_in
);
    initial
    begin
        byte_vld = 1'b0;
        byte_in = 8'h00;
    end
    // slow mode leaves a gap with the inverted byte on the bus
    task automatic send(input logic [39:0] b, input int n, input bit slow);
        int i;
        for (i = n - 1; i >= 0; i--)
        begin
            @(posedge clk);
            byte_vld <= 1'b1;
            byte_in <= b[i*8+:8];
            if (slow)
            begin
                @(posedge clk);
                byte_vld <= 1'b0;
                byte_in <= ~b[i*8+:8];
            end
        end
        @(posedge clk);
        byte_vld <= 1'b0;
        byte_in <= ~b[7:0];
    endtask
endmodule // ssx_prog_mem
`default_nettype wire

// file: test/tb_ssx_exec.sv
// self-checking bench for the execution block
// assumes ssx_pkg compiled first and ssx_prog_mem as byte source
`include "ssx_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_ssx_exec;
    typedef struct packed {
        ssx_pkg::ssx_kind_t kind;
        logic [3:0] states;
        logic [15:0] opd;
        logic chk_op;
        logic [7:0] acc;
        ssx_pkg::ssx_flags_t fl;
        logic [15:0] sp;
        logic [7:0] wd;
        logic bad;
    } ssx_exp_t;
    logic clk, rst_n, native_mode, byte_vld, dec_vld, int_block;
    logic mem_we, bad_opcode;
    logic [7:0] byte_in, src_byte, accumulator, mem_wdata, acc_m;
    ssx_pkg::ssx_dec_t dec;
    ssx_pkg::ssx_flags_t flags, fl_m;
    logic [15:0] stack_pointer_reg, sp_m;
    logic [23:0] program_counter;
    ssx_exp_t exp_q[$];
    ssx_exp_t m;
    int fail_count, samples_checked, cyc;
    ssx_exec ssx_exec_i (.clk(clk), .rst_n(rst_n), .ce(1'b1),
        .native_mode(native_mode), .byte_vld(byte_vld), .byte_in(byte_in),
        .src_byte(src_byte), .dec_vld(dec_vld), .dec(dec),
        .accumulator(accumulator), .flags(flags),
        .stack_pointer_reg(stack_pointer_reg),
        .program_counter(program_counter), .int_block(int_block),
        .mem_we(mem_we), .mem_wdata(mem_wdata), .bad_opcode(bad_opcode));
    ssx_prog_mem ssx_prog_mem_i (.clk(clk), .byte_vld(byte_vld),
        .byte_in(byte_in));
    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] ex);
        samples_checked++;
        if (seen !== ex)
        begin
            fail_count++;
            $display("mismatch t=%0t seen %h expected %h", $time, seen, ex);
        end
    endtask
    task automatic close_out;
        if (fail_count == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // one instruction: note the expectation, send bytes, await result
    task automatic run(input logic [39:0] b, input int n, input bit nat,
        input ssx_pkg::ssx_kind_t k, input logic [3:0] st, input bit bad,
        input bit sl);
        ssx_exp_t e;
        logic [7:0] s, v;
        logic [8:0] d;
        logic [4:0] h;
        int w;
        @(posedge clk);
        native_mode <= nat;
        s = 8'($urandom);
        src_byte <= s;
        if (n == 2 && b[15:8] == 8'h94)
            b[7:0] = 8'($urandom);
        v = (b[15:8] == 8'h94) ? b[7:0] : s;
        e = '0;
        e.kind = k;
        e.states = st;
        e.bad = bad;
        e.opd = b[15:0];
        e.chk_op = (k inside {ssx_pkg::SSX_K_SUB_B, ssx_pkg::SSX_K_SUB_W,
            ssx_pkg::SSX_K_SUB_D}) && (b[19:16] inside {4'h3, 4'h4, 4'h7, 4'h8});
        e.wd = acc_m;
        if (!bad)
        begin
            case (k)
                ssx_pkg::SSX_K_SBB:
                begin
                    d = {1'b0, acc_m} - {1'b0, v} - {8'h00, fl_m.cy};
                    h = {1'b0, acc_m[3:0]} - {1'b0, v[3:0]} - {4'h0, fl_m.cy};
                    fl_m.ov = (acc_m[7] != v[7]) && (d[7] != acc_m[7]);
                    fl_m.cy = d[8];
                    fl_m.ac = h[4];
                    acc_m = d[7:0];
                end
                ssx_pkg::SSX_K_SWAP: acc_m = {acc_m[3:0], acc_m[7:4]};
                ssx_pkg::SSX_K_XCH: acc_m = s;
                ssx_pkg::SSX_K_TRAP: sp_m = sp_m - 16'h0002;
                default: ;
            endcase
        end
        e.acc = acc_m;
        e.fl = fl_m;
        e.sp = sp_m;
        exp_q.push_back(e);
        ssx_prog_mem_i.send(b, n, sl);
        w = 0;
        while (exp_q.size() != 0 && w < 100)
        begin
            @(posedge clk);
            w++;
        end
        check(exp_q.size(), 0);
        check(w, bad ? (sl ? 0 : 1) : st + (sl ? 1 : 2));
    endtask
    ////////////////////////////////////////////////////////////////////
    // outputs are looked at mid-cycle, where they have settled
    always @(negedge clk)
        if (rst_n === 1'b1 && (dec_vld === 1'b1 || bad_opcode === 1'b1))
        begin
            if (exp_q.size() == 0)
                check(1, 0);
            else
            begin
                m = exp_q.pop_front();
                check(bad_opcode, m.bad);
                if (!m.bad)
                begin
                    check(dec.kind, m.kind);
                    check(dec.states, m.states);
                    if (m.chk_op)
                        check(dec.operand, m.opd);
                    check(accumulator, m.acc);
                    check(flags, m.fl);
                    check(stack_pointer_reg, m.sp);
                    check(int_block, m.kind == ssx_pkg::SSX_K_TRAP);
                    check(mem_we, m.kind == ssx_pkg::SSX_K_XCH);
                    if (m.kind == ssx_pkg::SSX_K_XCH)
                        check(mem_wdata, m.wd);
                    if (m.kind == ssx_pkg::SSX_K_TRAP)
                        check(program_counter, `SSX_TRAP_VEC);
                end
            end
        end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            close_out();
        end
    end
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        rst_n = 1'b0;
        native_mode = 1'b1;
        src_byte = 8'h00;
        acc_m = 8'h00;
        fl_m = '0;
        sp_m = 16'h0000;
        void'($urandom(71));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check(accumulator, 8'h00);
        check(stack_pointer_reg, 16'h0000);
        check(program_counter, 24'h000000);
        for (int sl = 0; sl < 2; sl++)
        begin
            run(40'h9e305a, 3, 1, ssx_pkg::SSX_K_SUB_B, 4'h2, 0, sl);
            run(40'h9e3412ab, 4, 1, ssx_pkg::SSX_K_SUB_W, 4'h3, 0, sl);
            run(40'h9e588001, 4, 1, ssx_pkg::SSX_K_SUB_D, 4'h5, 0, sl);
            run(40'h9e2140, 3, 1, ssx_pkg::SSX_K_SUB_B, 4'h2, 0, sl);
            run(40'h9e2102, 3, 1, ssx_pkg::SSX_K_SUB_B, 4'h3, 0, sl);
            run(40'h9e4540, 3, 1, ssx_pkg::SSX_K_SUB_W, 4'h3, 0, sl);
            run(40'h9e131234, 4, 1, ssx_pkg::SSX_K_SUB_B, 4'h2, 0, sl);
            run(40'h9e274321, 4, 1, ssx_pkg::SSX_K_SUB_W, 4'h3, 0, sl);
            run(40'h9e4950, 3, 1, ssx_pkg::SSX_K_SUB_B, 4'h2, 0, sl);
            run(40'h9e4b50, 3, 1, ssx_pkg::SSX_K_SUB_B, 4'h3, 0, sl);
            repeat (6) run(40'h9400, 2, 1, ssx_pkg::SSX_K_SBB, 4'h1, 0, sl);
            run(40'h9580, 2, 1, ssx_pkg::SSX_K_SBB, 4'h1, 0, sl);
            run(40'h9503, 2, 1, ssx_pkg::SSX_K_SBB, 4'h2, 0, sl);
            run(40'ha597, 2, 1, ssx_pkg::SSX_K_SBB, 4'h3, 0, sl);
            run(40'ha59b, 2, 1, ssx_pkg::SSX_K_SBB, 4'h2, 0, sl);
            run(40'hc4, 1, 1, ssx_pkg::SSX_K_SWAP, 4'h2, 0, sl);
            run(40'hb9, 1, 1, ssx_pkg::SSX_K_TRAP, 4'ha, 0, sl);
            run(40'hc530, 2, 1, ssx_pkg::SSX_K_XCH, 4'h3, 0, sl);
            run(40'hc500, 2, 1, ssx_pkg::SSX_K_XCH, 4'h5, 0, sl);
            run(40'h96, 1, 1, ssx_pkg::SSX_K_NONE, 4'h0, 1, sl);
            run(40'ha59e305a, 4, 0, ssx_pkg::SSX_K_SUB_B, 4'h3, 0, sl);
            run(40'ha59e588001, 5, 0, ssx_pkg::SSX_K_SUB_D, 4'h6, 0, sl);
            run(40'h96, 1, 0, ssx_pkg::SSX_K_SBB, 4'h2, 0, sl);
            run(40'h9c, 1, 0, ssx_pkg::SSX_K_SBB, 4'h1, 0, sl);
            run(40'h9400, 2, 0, ssx_pkg::SSX_K_SBB, 4'h1, 0, sl);
            run(40'h9e, 1, 0, ssx_pkg::SSX_K_NONE, 4'h0, 1, sl);
            run(40'ha596, 2, 0, ssx_pkg::SSX_K_NONE, 4'h0, 1, sl);
        end
        close_out();
    end
endmodule // tb_ssx_exec
`default_nettype wire
